// ===== verilog/rms_pkg.sv
// Constants, register map and carrier types of the room mode and setpoint
// block. Shared by the top module and the float conversion modules.
package rms_pkg;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   // Internal temperatures are signed hundredths of a kelvin.
   localparam int TEMP_W = 18;

   typedef logic signed [TEMP_W-1:0] rms_temp_t;
   typedef logic [DATA_W-1:0] rms_f16_t;

   // ------------------------------------------------------------------
   // Two-byte float layout
   // ------------------------------------------------------------------
   localparam int F16_SIGN_BIT = 15;
   localparam int F16_EXP_MSB = 14;
   localparam int F16_EXP_LSB = 11;
   localparam int F16_MANT_MSB = 10;
   localparam int F16_EXP_MAX = 15;
   localparam int MANT_MIN = -2048;
   localparam int MANT_MAX = 2047;

   // ------------------------------------------------------------------
   // Operating mode codes (objects 3 and 6)
   // ------------------------------------------------------------------
   localparam logic [1:0] MODE_COMFORT = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_NIGHT = 2'h2;
   localparam logic [1:0] MODE_PROTECT = 2'h3;

   // ------------------------------------------------------------------
   // Register map (word index on the plain register port)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_BASE = 6'h00;
   localparam logic [ADDR_W-1:0] A_OFFSET = 6'h01;
   localparam logic [ADDR_W-1:0] A_PRESET = 6'h03;
   localparam logic [ADDR_W-1:0] A_PRESENCE = 6'h04;
   localparam logic [ADDR_W-1:0] A_WINDOW = 6'h05;
   localparam logic [ADDR_W-1:0] A_CUR_MODE = 6'h06;
   localparam logic [ADDR_W-1:0] A_OFFSET_FB = 6'h0A;
   localparam logic [ADDR_W-1:0] A_CUR_SP = 6'h0B;
   localparam logic [ADDR_W-1:0] A_COOLING = 6'h0C;
   localparam logic [ADDR_W-1:0] A_STBY_RED = 6'h10;
   localparam logic [ADDR_W-1:0] A_NIGHT_RED = 6'h11;
   localparam logic [ADDR_W-1:0] A_FROST_SP = 6'h12;
   localparam logic [ADDR_W-1:0] A_DEAD_ZONE = 6'h13;
   localparam logic [ADDR_W-1:0] A_STBY_INC = 6'h14;
   localparam logic [ADDR_W-1:0] A_NIGHT_INC = 6'h15;
   localparam logic [ADDR_W-1:0] A_HEAT_SP = 6'h16;
   localparam logic [ADDR_W-1:0] A_MAX_OFS = 6'h17;
   localparam logic [ADDR_W-1:0] A_BASE_MIN = 6'h18;
   localparam logic [ADDR_W-1:0] A_BASE_MAX = 6'h19;

   // ------------------------------------------------------------------
   // Reset values, hundredths of a kelvin or degree
   // ------------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_BASE = 16'h0834;
   localparam logic [DATA_W-1:0] RST_STBY_RED = 16'h00C8;
   localparam logic [DATA_W-1:0] RST_NIGHT_RED = 16'h0190;
   localparam logic [DATA_W-1:0] RST_FROST_SP = 16'h02BC;
   localparam logic [DATA_W-1:0] RST_DEAD_ZONE = 16'h00C8;
   localparam logic [DATA_W-1:0] RST_STBY_INC = 16'h00C8;
   localparam logic [DATA_W-1:0] RST_NIGHT_INC = 16'h0190;
   localparam logic [DATA_W-1:0] RST_HEAT_SP = 16'h0DAC;
   localparam logic [DATA_W-1:0] RST_MAX_OFS = 16'h00C8;
   localparam logic [DATA_W-1:0] RST_BASE_MIN = 16'h03E8;
   localparam logic [DATA_W-1:0] RST_BASE_MAX = 16'h0BB8;

   // Configuration values, each signed hundredths.
   typedef struct packed {
      logic signed [DATA_W-1:0] stby_red;
      logic signed [DATA_W-1:0] night_red;
      logic signed [DATA_W-1:0] frost_sp;
      logic signed [DATA_W-1:0] dead_zone;
      logic signed [DATA_W-1:0] stby_inc;
      logic signed [DATA_W-1:0] night_inc;
      logic signed [DATA_W-1:0] heat_sp;
      logic signed [DATA_W-1:0] max_ofs;
      logic signed [DATA_W-1:0] base_min;
      logic signed [DATA_W-1:0] base_max;
   } rms_cfg_t;

endpackage

// ===== verilog/rms_f16_dec.sv
// Two-byte float to signed hundredths, combinational.
// Assumes the caller registers the result; saturates at the internal width.
module rms_f16_dec (
   input wire rms_pkg::rms_f16_t f16, // Two-byte float value
   output rms_pkg::rms_temp_t value // Signed hundredths, saturated
);

   logic signed [11:0] mant;
   logic [3:0] expo;
   logic signed [27:0] wide;

   // (R18) Float decode.
   always_comb begin
      mant = {f16[rms_pkg::F16_SIGN_BIT], f16[rms_pkg::F16_MANT_MSB:0]};
      expo = f16[rms_pkg::F16_EXP_MSB:rms_pkg::F16_EXP_LSB];
      wide = 28'(mant) <<< expo;
      if (wide > 28'sh001FFFF) begin
         value = 18'sh1FFFF;
      end else if (wide < -28'sh0020000) begin
         value = -18'sh20000;
      end else begin
         value = wide[rms_pkg::TEMP_W-1:0];
      end
   end

endmodule // rms_f16_dec

// ===== verilog/rms_f16_enc.sv
// Signed hundredths to two-byte float, combinational.
// Picks the smallest exponent whose mantissa fits; low bits are truncated.
module rms_f16_enc (
   input wire rms_pkg::rms_temp_t value, // Signed hundredths
   output rms_pkg::rms_f16_t f16 // Two-byte float value
);

   logic signed [rms_pkg::TEMP_W-1:0] shifted;
   logic [3:0] expo;
   logic found;

   // (R18) Float encode.
   always_comb begin
      shifted = value;
      expo = 4'h0;
      found = 1'b0;
      for (int e = 0; e <= rms_pkg::F16_EXP_MAX; e++) begin
         if (!found && (value >>> e) >= rms_pkg::MANT_MIN
             && (value >>> e) <= rms_pkg::MANT_MAX) begin
            found = 1'b1;
            expo = 4'(e);
            shifted = value >>> e;
         end
      end
      f16 = {shifted[11], expo, shifted[10:0]};
   end

endmodule // rms_f16_enc

// ===== verilog/rms_mode_setpoint.sv
// Room mode and setpoint logic for one channel: object registers, mode
// selection, setpoint formation, offset feedback.
// Assumes a register port master that keeps strobes one cycle long and
// never asserts read and write together; all inputs but arst_n are synchronous.
//
// Overview of operation
// (R1) Window forces protection, else presence forces comfort, else preset.
// (R2) Resulting mode is shown on its own output object.
// (R3) Heating comfort: base plus signed offset.
// (R4) Heating standby: base plus offset minus standby reduction.
// (R5) Base is comfort value and reference; night subtracts night reduction.
// (R6) Heating protection: frost setpoint, base and offset ignored.
// (R7) Cooling comfort: base plus offset plus dead zone.
// (R8) Cooling standby: additionally plus standby increase.
// (R9) Cooling night: additionally plus night increase.
// (R10) Cooling protection: heat protection setpoint.
// (R11) Sender writes the signed float differential to the offset object.
// (R12) Offset feedback is sent whenever the effective offset changes; in heating comfort the code sends only when the clamped shift changes.
// (R13) Received offset is limited to plus or minus the maximum offset.
// (R14) Each offset replaces the previous one, relative to the base.
// (R15) Base object starts from configuration and accepts writes anytime.
// (R16) Base writes outside the valid minimum and maximum are refused.
// (R17) Offset-adjusted setpoint is clamped to frost and heat setpoints.
// (R18) Floats: sign, 4-bit exponent, 11-bit mantissa, 0.01 scale.
// (R19) Mode and setpoint are recomputed the cycle after any change.
//
// Added by the designer: the address-and-strobe port and the address map.
module rms_mode_setpoint (
   input wire logic clk, // 10 MHz clock
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic [rms_pkg::ADDR_W-1:0] addr, // Register index
   input wire logic [rms_pkg::DATA_W-1:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [rms_pkg::DATA_W-1:0] rdata, // Read data, cycle after rd
   output logic [1:0] cur_mode, // Current operating mode object
   output rms_pkg::rms_f16_t cur_sp, // Current setpoint, float
   output rms_pkg::rms_f16_t offset_fb, // Offset feedback object, float
   output logic offset_fb_tx // One-cycle send pulse for feedback
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic rms_pkg::rms_temp_t limit(
      input rms_pkg::rms_temp_t v,
      input rms_pkg::rms_temp_t lo,
      input rms_pkg::rms_temp_t hi);
      rms_pkg::rms_temp_t r;
      r = v;
      if (v < lo) begin
         r = lo;
      end
      if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   function automatic rms_pkg::rms_temp_t ext(
      input logic signed [rms_pkg::DATA_W-1:0] v);
      return rms_pkg::TEMP_W'(v);
   endfunction

   // ------------------------------------------------------------------
   // Object and configuration registers
   // ------------------------------------------------------------------
   rms_pkg::rms_temp_t base_reg;
   rms_pkg::rms_temp_t offset_req_reg;
   logic [1:0] preset_reg;
   logic presence_reg;
   logic window_reg;
   logic cooling_reg;
   rms_pkg::rms_cfg_t cfg_reg;

   rms_pkg::rms_temp_t wdata_val;
   rms_pkg::rms_temp_t base_min;
   rms_pkg::rms_temp_t base_max;
   logic base_ok;

   rms_f16_dec u_dec (
      .f16(wdata),
      .value(wdata_val)
   );

   assign base_min = ext(cfg_reg.base_min);
   assign base_max = ext(cfg_reg.base_max);
   assign base_ok = (wdata_val >= base_min) && (wdata_val <= base_max);

   // (R15) Base object writes.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         base_reg <= rms_pkg::TEMP_W'(signed'(rms_pkg::RST_BASE));
      end else if (wr && addr == rms_pkg::A_BASE) begin
         // (R16) Range check on base.
         if (base_ok) begin
            base_reg <= wdata_val;
         end
      end
   end

   // (R14) Offset replaces previous.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         offset_req_reg <= '0;
      end else if (wr && addr == rms_pkg::A_OFFSET) begin
         offset_req_reg <= wdata_val;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         preset_reg <= rms_pkg::MODE_COMFORT;
         presence_reg <= 1'b0;
         window_reg <= 1'b0;
         cooling_reg <= 1'b0;
      end else if (wr) begin
         case (addr)
            rms_pkg::A_PRESET: preset_reg <= wdata[1:0];
            rms_pkg::A_PRESENCE: presence_reg <= wdata[0];
            rms_pkg::A_WINDOW: window_reg <= wdata[0];
            rms_pkg::A_COOLING: cooling_reg <= wdata[0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_reg.stby_red <= rms_pkg::RST_STBY_RED;
         cfg_reg.night_red <= rms_pkg::RST_NIGHT_RED;
         cfg_reg.frost_sp <= rms_pkg::RST_FROST_SP;
         cfg_reg.dead_zone <= rms_pkg::RST_DEAD_ZONE;
         cfg_reg.stby_inc <= rms_pkg::RST_STBY_INC;
         cfg_reg.night_inc <= rms_pkg::RST_NIGHT_INC;
         cfg_reg.heat_sp <= rms_pkg::RST_HEAT_SP;
         cfg_reg.max_ofs <= rms_pkg::RST_MAX_OFS;
         cfg_reg.base_min <= rms_pkg::RST_BASE_MIN;
         cfg_reg.base_max <= rms_pkg::RST_BASE_MAX;
      end else if (wr) begin
         case (addr)
            rms_pkg::A_STBY_RED: cfg_reg.stby_red <= wdata;
            rms_pkg::A_NIGHT_RED: cfg_reg.night_red <= wdata;
            rms_pkg::A_FROST_SP: cfg_reg.frost_sp <= wdata;
            rms_pkg::A_DEAD_ZONE: cfg_reg.dead_zone <= wdata;
            rms_pkg::A_STBY_INC: cfg_reg.stby_inc <= wdata;
            rms_pkg::A_NIGHT_INC: cfg_reg.night_inc <= wdata;
            rms_pkg::A_HEAT_SP: cfg_reg.heat_sp <= wdata;
            rms_pkg::A_MAX_OFS: cfg_reg.max_ofs <= wdata;
            rms_pkg::A_BASE_MIN: cfg_reg.base_min <= wdata;
            rms_pkg::A_BASE_MAX: cfg_reg.base_max <= wdata;
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Mode selection
   // ------------------------------------------------------------------
   logic [1:0] mode_next;

   // (R1) Mode priority.
   always_comb begin
      if (window_reg) begin
         mode_next = rms_pkg::MODE_PROTECT;
      end else if (presence_reg) begin
         mode_next = rms_pkg::MODE_COMFORT;
      end else begin
         mode_next = preset_reg;
      end
   end

   // ------------------------------------------------------------------
   // Setpoint formation
   // ------------------------------------------------------------------
   rms_pkg::rms_temp_t max_ofs;
   rms_pkg::rms_temp_t eff_ofs;
   rms_pkg::rms_temp_t adj;
   rms_pkg::rms_temp_t sp_raw;
   rms_pkg::rms_temp_t frost_sp;
   rms_pkg::rms_temp_t heat_sp;
   rms_pkg::rms_temp_t sp_next;

   assign max_ofs = ext(cfg_reg.max_ofs);
   assign frost_sp = ext(cfg_reg.frost_sp);
   assign heat_sp = ext(cfg_reg.heat_sp);

   // (R13) Offset limiting.
   assign eff_ofs = limit(offset_req_reg, -max_ofs, max_ofs);

   // Only the mode dependent shift is selected here, so base and offset
   // enter a single adder whatever the mode.
   always_comb begin
      adj = '0;
      if (cooling_reg) begin
         case (mode_next)
            // (R7) Cooling comfort shift.
            rms_pkg::MODE_COMFORT: adj = ext(cfg_reg.dead_zone);
            // (R8) Cooling standby shift.
            rms_pkg::MODE_STANDBY:
               adj = ext(cfg_reg.dead_zone) + ext(cfg_reg.stby_inc);
            // (R9) Cooling night shift.
            rms_pkg::MODE_NIGHT:
               adj = ext(cfg_reg.dead_zone) + ext(cfg_reg.night_inc);
            default: adj = '0;
         endcase
      end else begin
         case (mode_next)
            // (R3) Heating comfort shift.
            rms_pkg::MODE_COMFORT: adj = '0;
            // (R4) Heating standby reduction.
            rms_pkg::MODE_STANDBY: adj = -ext(cfg_reg.stby_red);
            // (R5) Night reduction.
            rms_pkg::MODE_NIGHT: adj = -ext(cfg_reg.night_red);
            default: adj = '0;
         endcase
      end
   end

   // (R5) Base as reference.
   assign sp_raw = base_reg + eff_ofs + adj;

   always_comb begin
      if (mode_next == rms_pkg::MODE_PROTECT) begin
         // (R10) Cooling protection setpoint.
         if (cooling_reg) begin
            sp_next = heat_sp;
         end else begin
            // (R6) Frost protection setpoint.
            sp_next = frost_sp;
         end
      end else begin
         // (R17) Safety limits.
         sp_next = limit(sp_raw, frost_sp, heat_sp);
      end
   end

   // ------------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------------
   rms_pkg::rms_f16_t sp_f16;
   rms_pkg::rms_f16_t fb_f16;
   rms_pkg::rms_temp_t fb_val;
   rms_pkg::rms_temp_t fb_last_reg;

   // In heating comfort, feedback is the shift that the offset really caused, so a safety
   // clamp is reported as well as the offset limit; in other modes it is the limited offset.
   assign fb_val = (mode_next == rms_pkg::MODE_COMFORT && !cooling_reg)
                   ? limit(base_reg + eff_ofs, frost_sp, heat_sp) - base_reg
                   : eff_ofs;

   rms_f16_enc u_enc_sp (
      .value(sp_next),
      .f16(sp_f16)
   );

   rms_f16_enc u_enc_fb (
      .value(fb_val),
      .f16(fb_f16)
   );

   // (R19) One-cycle recompute.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_mode <= rms_pkg::MODE_COMFORT;
         cur_sp <= '0;
      end else begin
         // (R2) Mode output object.
         cur_mode <= mode_next;
         cur_sp <= sp_f16;
      end
   end

   // (R12) Feedback on change.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fb_last_reg <= '0;
         offset_fb <= '0;
         offset_fb_tx <= 1'b0;
      end else begin
         offset_fb_tx <= (fb_val != fb_last_reg);
         if (fb_val != fb_last_reg) begin
            fb_last_reg <= fb_val;
            offset_fb <= fb_f16;
         end
      end
   end

   // ------------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------------
   logic [rms_pkg::DATA_W-1:0] rd_mux;
   rms_pkg::rms_f16_t base_f16;
   rms_pkg::rms_f16_t ofs_f16;

   rms_f16_enc u_enc_base (
      .value(base_reg),
      .f16(base_f16)
   );

   rms_f16_enc u_enc_ofs (
      .value(eff_ofs),
      .f16(ofs_f16)
   );

   always_comb begin
      case (addr)
         rms_pkg::A_BASE: rd_mux = base_f16;
         rms_pkg::A_OFFSET: rd_mux = ofs_f16;
         rms_pkg::A_PRESET: rd_mux = {14'h0000, preset_reg};
         rms_pkg::A_PRESENCE: rd_mux = {15'h0000, presence_reg};
         rms_pkg::A_WINDOW: rd_mux = {15'h0000, window_reg};
         rms_pkg::A_CUR_MODE: rd_mux = {14'h0000, cur_mode};
         rms_pkg::A_OFFSET_FB: rd_mux = offset_fb;
         rms_pkg::A_CUR_SP: rd_mux = cur_sp;
         rms_pkg::A_COOLING: rd_mux = {15'h0000, cooling_reg};
         rms_pkg::A_STBY_RED: rd_mux = cfg_reg.stby_red;
         rms_pkg::A_NIGHT_RED: rd_mux = cfg_reg.night_red;
         rms_pkg::A_FROST_SP: rd_mux = cfg_reg.frost_sp;
         rms_pkg::A_DEAD_ZONE: rd_mux = cfg_reg.dead_zone;
         rms_pkg::A_STBY_INC: rd_mux = cfg_reg.stby_inc;
         rms_pkg::A_NIGHT_INC: rd_mux = cfg_reg.night_inc;
         rms_pkg::A_HEAT_SP: rd_mux = cfg_reg.heat_sp;
         rms_pkg::A_MAX_OFS: rd_mux = cfg_reg.max_ofs;
         rms_pkg::A_BASE_MIN: rd_mux = cfg_reg.base_min;
         rms_pkg::A_BASE_MAX: rd_mux = cfg_reg.base_max;
         default: rd_mux = 16'h0000;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 16'h0000;
      end else if (rd) begin
         rdata <= rd_mux;
      end else begin
         rdata <= 16'h0000;
      end
   end

endmodule // rms_mode_setpoint

// ===== test/rms_mode_setpoint_monitor.sv
// Port checker for the room mode and setpoint block.
// Assumes it is bound to the top module and shares its single clock domain.
module rms_mode_setpoint_monitor (
   input wire logic clk, // Block clock
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic [rms_pkg::ADDR_W-1:0] addr, // Register index
   input wire logic [rms_pkg::DATA_W-1:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   input wire logic [rms_pkg::DATA_W-1:0] rdata, // Read data
   input wire logic [1:0] cur_mode, // Current mode object
   input wire rms_pkg::rms_f16_t cur_sp, // Current setpoint
   input wire rms_pkg::rms_f16_t offset_fb, // Offset feedback
   input wire logic offset_fb_tx // Feedback send pulse
);
   timeunit 1ns;
   timeprecision 1ns;

   logic win_q;
   logic pres_q;
   logic [1:0] pre_q;
   logic [1:0] exp_mode;
   logic [1:0] up_cnt;

   // ------------
   // Shadow of the mode inputs
   // ------------
   // Written with the block's objects, so it leads the mode output.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         win_q <= 1'h0;
         pres_q <= 1'h0;
         pre_q <= 2'h0;
      end else if (wr) begin
         if (addr == rms_pkg::A_WINDOW) win_q <= wdata[0];
         if (addr == rms_pkg::A_PRESENCE) pres_q <= wdata[0];
         if (addr == rms_pkg::A_PRESET) pre_q <= wdata[1:0];
      end
   end

   assign exp_mode = win_q ? rms_pkg::MODE_PROTECT :
                     (pres_q ? rms_pkg::MODE_COMFORT : pre_q);

   // The first setpoint move after reset has no write behind it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) up_cnt <= 2'h0;
      else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
   end

   // ------------
   // Assertions
   // ------------
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   mode_table_a: assert property (cur_mode == $past(exp_mode))
      else $error("mode priority wrong");
   window_prot_a: assert property (
      wr && addr == rms_pkg::A_WINDOW && wdata[0]
      |-> ##2 cur_mode == rms_pkg::MODE_PROTECT)
      else $error("window not protected");
   mode_read_a: assert property (
      rd && addr == rms_pkg::A_CUR_MODE |=> rdata == {14'h0, $past(cur_mode)})
      else $error("mode read wrong");
   sp_read_a: assert property (
      rd && addr == rms_pkg::A_CUR_SP |=> rdata == $past(cur_sp))
      else $error("setpoint read wrong");
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
      else $error("read data not idle");
   fb_change_a: assert property (
      offset_fb_tx == (offset_fb != $past(offset_fb)))
      else $error("send pulse without change");
   fb_cause_a: assert property (offset_fb_tx |-> $past(wr, 2))
      else $error("send without write");
   sp_cause_a: assert property (
      up_cnt == 2'h3 && $changed(cur_sp) |-> $past(wr, 2))
      else $error("setpoint moved unprompted");
endmodule // rms_mode_setpoint_monitor

// ===== test/rms_bus_peer.sv
// Listener standing for the bus devices that receive the feedback object.
// Assumes the send pulse is one cycle long and synchronous to clk.
module rms_bus_peer (
   input wire logic clk, // Block clock
   input wire logic arst_n, // Asynchronous reset, active low
   input wire rms_pkg::rms_f16_t offset_fb, // Feedback object value
   input wire logic offset_fb_tx, // Feedback send pulse
   output logic [7:0] n_tel, // Telegrams heard so far
   output rms_pkg::rms_f16_t last_fb // Value of the last telegram
);
   timeunit 1ns;
   timeprecision 1ns;

   // Only a pulse counts as a telegram; a value change without it is lost.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         n_tel <= 8'h00;
         last_fb <= 16'h0000;
      end else if (offset_fb_tx) begin
         n_tel <= n_tel + 8'h01;
         last_fb <= offset_fb;
      end
   end
endmodule // rms_bus_peer

// ===== test/rms_mode_setpoint_test.sv
// Self-checking bench for the room mode and setpoint block.
// Assumes the register port contract: one-cycle strobes, read data next cycle.
module rms_mode_setpoint_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic [rms_pkg::ADDR_W-1:0] addr = '0;
   logic [rms_pkg::DATA_W-1:0] wdata = '0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [rms_pkg::DATA_W-1:0] rdata;
   logic [1:0] cur_mode;
   rms_pkg::rms_f16_t cur_sp;
   rms_pkg::rms_f16_t offset_fb;
   rms_pkg::rms_f16_t last_fb;
   logic offset_fb_tx;
   logic [7:0] n_tel;
   int n_mismatch = 0;
   int checks_done = 0;

   always #50 clk = ~clk;

   rms_mode_setpoint DUT (.clk(clk), .arst_n(arst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cur_mode(cur_mode),
      .cur_sp(cur_sp), .offset_fb(offset_fb), .offset_fb_tx(offset_fb_tx));

   rms_bus_peer peer (.clk(clk), .arst_n(arst_n), .offset_fb(offset_fb),
      .offset_fb_tx(offset_fb_tx), .n_tel(n_tel), .last_fb(last_fb));

   // ------------
   // Helpers
   // ------------
   // Float of v: smallest exponent that fits.
   function automatic logic [15:0] enc(input int v);
      int e = 0;
      while (v > 2047 || v < -2048) begin
         v = v >>> 1;
         e++;
      end
      return {v[11], e[3:0], v[10:0]};
   endfunction

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask

   task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      d = rdata;
   endtask

   // Outputs settle two edges after a write.
   task automatic put(input logic [5:0] a, input logic [15:0] d);
      wr_reg(a, d);
      repeat (3) @(negedge clk);
   endtask

   task automatic sweep(input string what, input int s0, s1, s2, s3);
      int tab [4];
      tab = '{s0, s1, s2, s3};
      for (int m = 0; m < 4; m++) begin
         put(rms_pkg::A_PRESET, 16'(m));
         check(what, cur_sp, enc(tab[m]));
      end
      put(rms_pkg::A_PRESET, 16'h0000);
   endtask

   // ------------
   // Scenarios
   // ------------
   task automatic t_reset;
      logic [15:0] d;
      logic [15:0] tab [10] = '{rms_pkg::RST_STBY_RED, rms_pkg::RST_NIGHT_RED,
         rms_pkg::RST_FROST_SP, rms_pkg::RST_DEAD_ZONE, rms_pkg::RST_STBY_INC,
         rms_pkg::RST_NIGHT_INC, rms_pkg::RST_HEAT_SP, rms_pkg::RST_MAX_OFS,
         rms_pkg::RST_BASE_MIN, rms_pkg::RST_BASE_MAX};
      repeat (3) @(negedge clk);
      check("reset_mode", {14'h0, cur_mode}, 16'h0000);
      check("reset_sp", cur_sp, enc(2100));
      for (int i = 0; i < 10; i++) begin
         rd_reg(6'h10 + 6'(i), d);
         check("config", d, tab[i]);
      end
      wr_reg(6'h3F, 16'hFFFF);
      rd_reg(6'h3F, d);
      check("unmapped", d, 16'h0000);
   endtask

   task automatic t_modes;
      logic [15:0] d;
      logic [1:0] e;
      for (int i = 0; i < 16; i++) begin
         put(rms_pkg::A_PRESET, 16'(i & 3));
         put(rms_pkg::A_PRESENCE, 16'((i >> 2) & 1));
         put(rms_pkg::A_WINDOW, 16'((i >> 3) & 1));
         e = i[3] ? rms_pkg::MODE_PROTECT :
             (i[2] ? rms_pkg::MODE_COMFORT : 2'(i));
         check("mode", {14'h0, cur_mode}, {14'h0, e});
         rd_reg(rms_pkg::A_CUR_MODE, d);
         check("mode_obj", d, {14'h0, e});
      end
      put(rms_pkg::A_WINDOW, 16'h0000);
      put(rms_pkg::A_PRESENCE, 16'h0000);
   endtask

   task automatic t_heat;
      logic [15:0] d;
      put(rms_pkg::A_OFFSET, enc(100));
      sweep("heat_sp", 2200, 2000, 1800, 700);
      put(rms_pkg::A_OFFSET, enc(50));
      check("replace", cur_sp, enc(2150));
      check("fb_replace", offset_fb, enc(50));
      rd_reg(rms_pkg::A_CUR_SP, d);
      check("sp_obj", d, enc(2150));
   endtask

   task automatic t_cool;
      put(rms_pkg::A_COOLING, 16'h0001);
      put(rms_pkg::A_OFFSET, enc(-100));
      sweep("cool_sp", 2200, 2400, 2600, 3500);
      put(rms_pkg::A_COOLING, 16'h0000);
   endtask

   task automatic t_limit;
      logic [7:0] n0;
      n0 = n_tel;
      put(rms_pkg::A_OFFSET, enc(500));
      check("limit_hi", cur_sp, enc(2300));
      check("fb_hi", last_fb, enc(200));
      check("tel_one", {8'h0, n_tel}, {8'h0, n0 + 8'h01});
      n0 = n_tel;
      put(rms_pkg::A_OFFSET, enc(500));
      check("tel_none", {8'h0, n_tel}, {8'h0, n0});
      put(rms_pkg::A_OFFSET, enc(-500));
      check("limit_lo", cur_sp, enc(1900));
      check("fb_lo", last_fb, enc(-200));
   endtask

   task automatic t_base;
      put(rms_pkg::A_BASE, enc(3500));
      check("base_hi", cur_sp, enc(1900));
      put(rms_pkg::A_BASE, enc(2200));
      check("base_ok", cur_sp, enc(2000));
      put(rms_pkg::A_BASE, enc(900));
      check("base_lo", cur_sp, enc(2000));
   endtask

   task automatic t_clamp;
      put(rms_pkg::A_HEAT_SP, 16'h0866);
      put(rms_pkg::A_OFFSET, enc(200));
      check("clamp_hi", cur_sp, enc(2150));
      check("fb_clamp", last_fb, enc(-50));
      put(rms_pkg::A_OFFSET, enc(-200));
      put(rms_pkg::A_FROST_SP, 16'h0834);
      check("clamp_lo", cur_sp, enc(2100));
   endtask

   // ------------
   // Sequence and watchdog
   // ------------
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'h1;
      t_reset;
      t_modes;
      t_heat;
      t_cool;
      t_limit;
      t_base;
      t_clamp;
      give_verdict;
   end

   // A hang ends the run as a failure.
   initial begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      give_verdict;
   end
endmodule // rms_mode_setpoint_test

bind rms_mode_setpoint rms_mode_setpoint_monitor u_mon (.clk(clk),
   .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .cur_mode(cur_mode), .cur_sp(cur_sp),
   .offset_fb(offset_fb), .offset_fb_tx(offset_fb_tx));
